// ==== verilog/alu_core.sv ====
`timescale 1ns/1ps
`include "alu_defs.svh"

module alu_core
   import alu_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        op_valid,
   input  wire op_t         op_code,
   input  wire logic        op_word,
   input  wire logic        op_use_imm,
   input  wire logic        small_const_two,
   input  wire logic [15:0] dst_value,
   input  wire logic [15:0] src_value,
   input  wire logic [15:0] imm_value,
   output logic      [15:0] result_q,
   output logic             result_write_q,
   output logic             result_valid_q,
   output logic             rejected_q,
   output logic             busy_q,
   output logic             flag_n_q,
   output logic             flag_z_q,
   output logic             flag_v_q,
   output logic             flag_c_q,
   output logic             flag_h_q
);

   // ****************************************************************
   // operand selection
   // ****************************************************************
   div_if       dv ();
   logic [7:0]  dst_b;
   logic [7:0]  opnd_b;
   logic [7:0]  add_a;
   logic [7:0]  add_b;
   logic        add_cin;
   logic        add_sub;
   logic [7:0]  add_sum;
   logic        add_cout;
   logic        add_ovf;
   logic        add_half;
   logic [15:0] wadd_b;
   logic        wadd_sub;
   logic [15:0] wadd_sum;
   logic        wadd_cout;
   logic        wadd_ovf;
   logic        take;
   logic        illegal;
   logic        div_start_q;

   assign dst_b  = dst_value[`BYTE_MSB:0];
   assign opnd_b = op_use_imm ? imm_value[`BYTE_MSB:0] : src_value[`BYTE_MSB:0];
   assign take   = op_valid && !busy_q;

   // byte adder inputs per operation
   always_comb begin
      add_a   = dst_b;
      add_b   = opnd_b;
      add_cin = 1'b0;
      add_sub = 1'b0;
      case (op_code)
         op_sub, op_compare_operands: begin
            add_sub = 1'b1;
         end
         op_add_with_carry: begin
            add_cin = flag_c_q;
         end
         op_subtract_with_borrow: begin
            add_cin = flag_c_q;
            add_sub = 1'b1;
         end
         op_step_up_by_one: begin
            add_b = `BYTE_ONE;
         end
         op_step_down_by_one: begin
            add_b   = `BYTE_ONE;
            add_sub = 1'b1;
         end
         op_arithmetic_complement: begin
            add_a   = `BYTE_ZERO;
            add_b   = dst_b;
            add_sub = 1'b1;
         end
         default: begin
            add_a = dst_b;
         end
      endcase
   end

   // word adder: register pair or the small constant 1 / 2
   always_comb begin
      wadd_b   = src_value;
      wadd_sub = 1'b0;
      case (op_code)
         op_sub, op_compare_operands: begin
            wadd_sub = 1'b1;
         end
         op_word_small_constant_add: begin
            wadd_b = small_const_two ? `WORD_TWO : `WORD_ONE;
         end
         op_word_small_constant_subtract: begin
            wadd_b   = small_const_two ? `WORD_TWO : `WORD_ONE;
            wadd_sub = 1'b1;
         end
         default: begin
            wadd_sub = 1'b0;
         end
      endcase
   end

   // one adder per operand size, same structure
   addsub_unit #(.W(8)) byte_add (
      .a    (add_a),
      .b    (add_b),
      .cin  (add_cin),
      .sub  (add_sub),
      .sum  (add_sum),
      .cout (add_cout),
      .ovf  (add_ovf),
      .half (add_half)
   );

   addsub_unit #(.W(16)) word_add (
      .a    (dst_value),
      .b    (wadd_b),
      .cin  (1'b0),
      .sub  (wadd_sub),
      .sum  (wadd_sum),
      .cout (wadd_cout),
      .ovf  (wadd_ovf),
      .half ()
   );

   div_unit divider (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .dv      (dv.unit)
   );

   // ****************************************************************
   // forbidden operand forms
   // ****************************************************************
   // an illegal form is answered with rejected_q, no write, no flag change
   always_comb begin
      illegal = 1'b0;
      case (op_code)
         op_add: begin
            illegal = op_word && op_use_imm;
         end
         op_sub: begin
            illegal = op_use_imm;
         end
         op_compare_operands: begin
            illegal = op_word && op_use_imm;
         end
         op_word_small_constant_add, op_word_small_constant_subtract, op_unsigned_multiply,
         op_unsigned_divide: begin
            illegal = 1'b0;
         end
         default: begin
            illegal = op_word;
         end
      endcase
      if (op_code inside {op_unsigned_multiply, op_unsigned_divide}) begin
         illegal = op_use_imm;
      end
   end

   // ****************************************************************
   // result and flag computation
   // ****************************************************************
   logic [15:0] res_d;
   logic        wr_d;
   logic        n_d;
   logic        z_d;
   logic        v_d;
   logic        c_d;
   logic        h_d;
   logic [7:0]  bcd_fix;
   logic        bcd_c;

   // decimal correction from the flags of the previous byte operation
   always_comb begin
      bcd_fix = `BYTE_ZERO;
      bcd_c   = flag_c_q;
      if (op_code == op_decimal_adjust_after_add) begin
         if (flag_h_q || (dst_b[`NIBBLE_MSB:0] > `BCD_DIGIT_MAX)) begin
            bcd_fix = bcd_fix | `BCD_LOW_FIX;
         end
         if (flag_c_q || (dst_b > `BCD_BYTE_MAX)) begin
            bcd_fix = bcd_fix | `BCD_HIGH_FIX;
            bcd_c   = 1'b1;
         end
      end else begin
         if (flag_h_q) begin
            bcd_fix = bcd_fix | `BCD_LOW_FIX;
         end
         if (flag_c_q) begin
            bcd_fix = bcd_fix | `BCD_HIGH_FIX;
         end
      end
   end

   always_comb begin
      res_d = {dst_value[`WORD_MSB:8], add_sum};
      wr_d  = 1'b1;
      n_d   = flag_n_q;
      z_d   = flag_z_q;
      v_d   = flag_v_q;
      c_d   = flag_c_q;
      h_d   = flag_h_q;
      case (op_code)
         op_add, op_sub, op_compare_operands: begin
            if (op_word) begin
               res_d = wadd_sum;
               c_d   = wadd_cout;
               v_d   = wadd_ovf;
            end else begin
               c_d   = add_cout;
               v_d   = add_ovf;
               h_d   = add_half;
            end
            wr_d = (op_code != op_compare_operands);
         end
         op_add_with_carry, op_subtract_with_borrow, op_arithmetic_complement: begin
            c_d = add_cout;
            v_d = add_ovf;
            h_d = add_half;
         end
         op_step_up_by_one, op_step_down_by_one: begin
            v_d = add_ovf;
         end
         op_word_small_constant_add, op_word_small_constant_subtract: begin
            res_d = wadd_sum;
         end
         op_decimal_adjust_after_add: begin
            res_d[7:0] = dst_b + bcd_fix;
            c_d        = bcd_c;
         end
         op_decimal_adjust_after_subtract: begin
            res_d[7:0] = dst_b - bcd_fix;
         end
         op_unsigned_multiply: begin
            res_d = {8'h00, dst_b} * {8'h00, src_value[`BYTE_MSB:0]};
         end
         op_and: begin
            res_d[7:0] = dst_b & opnd_b;
            v_d        = 1'b0;
         end
         op_or: begin
            res_d[7:0] = dst_b | opnd_b;
            v_d        = 1'b0;
         end
         op_xor: begin
            res_d[7:0] = dst_b ^ opnd_b;
            v_d        = 1'b0;
         end
         op_not: begin
            res_d[7:0] = ~dst_b;
            v_d        = 1'b0;
         end
         op_arith_left_shift: begin
            res_d[7:0] = {dst_b[6:0], 1'b0};
            c_d        = dst_b[7];
            v_d        = dst_b[7] ^ dst_b[6];
         end
         op_arith_right_shift: begin
            res_d[7:0] = {dst_b[7], dst_b[7:1]};
            c_d        = dst_b[0];
            v_d        = 1'b0;
         end
         op_logical_left_shift: begin
            res_d[7:0] = {dst_b[6:0], 1'b0};
            c_d        = dst_b[7];
            v_d        = 1'b0;
         end
         op_logical_right_shift: begin
            res_d[7:0] = {1'b0, dst_b[7:1]};
            c_d        = dst_b[0];
            v_d        = 1'b0;
         end
         op_rotate_left: begin
            res_d[7:0] = {dst_b[6:0], dst_b[7]};
            c_d        = dst_b[7];
            v_d        = 1'b0;
         end
         op_rotate_right: begin
            res_d[7:0] = {dst_b[0], dst_b[7:1]};
            c_d        = dst_b[0];
            v_d        = 1'b0;
         end
         op_rotate_left_through_carry: begin
            res_d[7:0] = {dst_b[6:0], flag_c_q};
            c_d        = dst_b[7];
            v_d        = 1'b0;
         end
         op_rotate_right_through_carry: begin
            res_d[7:0] = {flag_c_q, dst_b[7:1]};
            c_d        = dst_b[0];
            v_d        = 1'b0;
         end
         default: begin
            wr_d = 1'b0;
         end
      endcase
      // multiply and the word constant steps leave the flags alone
      if (!(op_code inside {op_unsigned_multiply, op_word_small_constant_add,
                            op_word_small_constant_subtract})) begin
         if (op_word) begin
            n_d = res_d[`WORD_MSB];
            z_d = (res_d == `WORD_ZERO);
         end else begin
            n_d = res_d[`BYTE_MSB];
            z_d = (res_d[7:0] == `BYTE_ZERO);
         end
      end
   end

   // ****************************************************************
   // divider hand-off
   // ****************************************************************
   assign dv.start    = div_start_q;
   assign dv.dividend = dst_value;
   assign dv.divisor  = src_value[`BYTE_MSB:0];

   // operands must stay steady while busy_q is high
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         div_start_q <= 1'b0;
      end else begin
         div_start_q <= take && !illegal && (op_code == op_unsigned_divide);
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         busy_q <= 1'b0;
      end else if (take && !illegal && (op_code == op_unsigned_divide)) begin
         busy_q <= 1'b1;
      end else if (dv.done) begin
         busy_q <= 1'b0;
      end
   end

   // ****************************************************************
   // result register
   // ****************************************************************
   logic div_zero;

   // zero divisor gives no write: the destination keeps its value
   assign div_zero = (src_value[`BYTE_MSB:0] == `BYTE_ZERO);

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         result_q       <= `RESULT_RST;
         result_write_q <= 1'b0;
         result_valid_q <= 1'b0;
         rejected_q     <= 1'b0;
      end else begin
         result_valid_q <= 1'b0;
         result_write_q <= 1'b0;
         rejected_q     <= 1'b0;
         if (dv.done) begin
            result_q       <= {dv.remainder, dv.quotient};
            result_write_q <= !div_zero;
            result_valid_q <= 1'b1;
         end else if (take && illegal) begin
            rejected_q     <= 1'b1;
            result_valid_q <= 1'b1;
         end else if (take && (op_code != op_unsigned_divide)) begin
            result_q       <= res_d;
            result_write_q <= wr_d;
            result_valid_q <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // condition flags
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         flag_n_q <= `FLAG_RST;
         flag_z_q <= `FLAG_RST;
         flag_v_q <= `FLAG_RST;
         flag_c_q <= `FLAG_RST;
         flag_h_q <= `FLAG_RST;
      end else if (dv.done) begin
         flag_n_q <= dv.quotient[`BYTE_MSB];
         flag_z_q <= div_zero;
      end else if (take && !illegal && (op_code != op_unsigned_divide)) begin
         flag_n_q <= n_d;
         flag_z_q <= z_d;
         flag_v_q <= v_d;
         flag_c_q <= c_d;
         flag_h_q <= h_d;
      end
   end

endmodule : alu_core

// ==== verilog/alu_defs.svh ====
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH

// ****************************************************************
// widths and field positions
// ****************************************************************
`define BYTE_MSB        7
`define WORD_MSB        15
`define NIBBLE_MSB      3
`define OP_CODE_W       5

// ****************************************************************
// reset values
// ****************************************************************
`define RESULT_RST      16'h0000
`define FLAG_RST        1'b0
`define BYTE_ZERO       8'h00
`define WORD_ZERO       16'h0000

// ****************************************************************
// constants of the operations
// ****************************************************************
`define BYTE_ONE        8'h01
`define WORD_ONE        16'h0001
`define WORD_TWO        16'h0002
`define BCD_DIGIT_MAX   4'h9
`define BCD_BYTE_MAX    8'h99
`define BCD_LOW_FIX     8'h06
`define BCD_HIGH_FIX    8'h60

// ****************************************************************
// timing counts
// ****************************************************************
`define DIV_STEPS       4'h8
`define DIV_STEP_ZERO   4'h0

`endif

// ==== verilog/alu_pkg.sv ====
package alu_pkg;

   // ****************************************************************
   // operation codes from the decoder
   // ****************************************************************
   typedef enum logic [4:0] {
      op_add                        = 5'h00,
      op_sub                        = 5'h01,
      op_add_with_carry             = 5'h02,
      op_subtract_with_borrow       = 5'h03,
      op_step_up_by_one             = 5'h04,
      op_step_down_by_one           = 5'h05,
      op_word_small_constant_add    = 5'h06,
      op_word_small_constant_subtract = 5'h07,
      op_decimal_adjust_after_add   = 5'h08,
      op_decimal_adjust_after_subtract = 5'h09,
      op_unsigned_multiply          = 5'h0a,
      op_unsigned_divide            = 5'h0b,
      op_compare_operands           = 5'h0c,
      op_arithmetic_complement      = 5'h0d,
      op_and                        = 5'h0e,
      op_or                         = 5'h0f,
      op_xor                        = 5'h10,
      op_not                        = 5'h11,
      op_arith_left_shift           = 5'h12,
      op_arith_right_shift          = 5'h13,
      op_logical_left_shift         = 5'h14,
      op_logical_right_shift        = 5'h15,
      op_rotate_left                = 5'h16,
      op_rotate_right               = 5'h17,
      op_rotate_left_through_carry  = 5'h18,
      op_rotate_right_through_carry = 5'h19
   } op_t;

   // ****************************************************************
   // divider sequencer states
   // ****************************************************************
   typedef enum logic [2:0] {
      div_idle = 3'b001,
      div_run  = 3'b010,
      div_done = 3'b100
   } div_state_t;

endpackage : alu_pkg

// ==== verilog/div_if.sv ====
`timescale 1ns/1ps

interface div_if;
   logic        start;
   logic [15:0] dividend;
   logic [7:0]  divisor;
   logic        done;
   logic [7:0]  quotient;
   logic [7:0]  remainder;

   modport core (output start, output dividend, output divisor,
                 input done, input quotient, input remainder);
   modport unit (input start, input dividend, input divisor,
                 output done, output quotient, output remainder);
endinterface : div_if

// ==== verilog/addsub_unit.sv ====
`timescale 1ns/1ps

module addsub_unit #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] a,
   input  wire logic [W-1:0] b,
   input  wire logic         cin,
   input  wire logic         sub,
   output logic      [W-1:0] sum,
   output logic              cout,
   output logic              ovf,
   output logic              half
);
   logic [W-1:0] b_eff;
   logic         c_eff;
   logic [W:0]   full;
   logic [4:0]   low;

   // subtraction as a + ~b + ~borrow, carry out inverted to a borrow
   assign b_eff = sub ? ~b : b;
   assign c_eff = sub ? ~cin : cin;
   assign full  = {1'b0, a} + {1'b0, b_eff} + {{W{1'b0}}, c_eff};
   assign low   = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
   assign sum   = full[W-1:0];
   assign cout  = sub ? ~full[W] : full[W];
   assign half  = sub ? ~low[4] : low[4];
   assign ovf   = (a[W-1] ^ full[W-1]) & (b_eff[W-1] ^ full[W-1]);
endmodule : addsub_unit

// ==== verilog/div_unit.sv ====
`timescale 1ns/1ps
`include "alu_defs.svh"

module div_unit
   import alu_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic resetn,
   div_if.unit       dv
);
   div_state_t  state_q;
   logic [3:0]  step_q;
   logic [8:0]  rem_q;
   logic [7:0]  quo_q;
   logic [7:0]  low_q;
   logic [8:0]  trial;

   assign trial        = {rem_q[7:0], low_q[`BYTE_MSB]};
   assign dv.done      = (state_q == div_done);
   assign dv.quotient  = quo_q;
   assign dv.remainder = rem_q[7:0];

   // ****************************************************************
   // restoring division, one quotient bit a cycle
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= div_idle;
         step_q  <= `DIV_STEP_ZERO;
         rem_q   <= 9'h000;
         quo_q   <= `BYTE_ZERO;
         low_q   <= `BYTE_ZERO;
      end else begin
         case (state_q)
            div_idle: begin
               if (dv.start) begin
                  rem_q   <= {1'b0, dv.dividend[15:8]};
                  low_q   <= dv.dividend[7:0];
                  quo_q   <= `BYTE_ZERO;
                  step_q  <= `DIV_STEP_ZERO;
                  state_q <= div_run;
               end
            end
            div_run: begin
               if (trial >= {1'b0, dv.divisor}) begin
                  rem_q <= trial - {1'b0, dv.divisor};
                  quo_q <= {quo_q[6:0], 1'b1};
               end else begin
                  rem_q <= trial;
                  quo_q <= {quo_q[6:0], 1'b0};
               end
               low_q  <= {low_q[6:0], 1'b0};
               step_q <= step_q + 4'h1;
               if (step_q == `DIV_STEPS - 4'h1) begin
                  state_q <= div_done;
               end
            end
            div_done: begin
               state_q <= div_idle;
            end
            default: begin
               state_q <= div_idle;
            end
         endcase
      end
   end
endmodule : div_unit

// ==== test/alu_core_properties.sv ====
`timescale 1ns/1ps
module alu_core_properties
   import alu_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic        op_valid,
   input wire op_t         op_code,
   input wire logic        op_word,
   input wire logic        op_use_imm,
   input wire logic [15:0] dst_value,
   input wire logic [15:0] src_value,
   input wire logic [15:0] result_q,
   input wire logic        result_write_q,
   input wire logic        result_valid_q,
   input wire logic        rejected_q,
   input wire logic        busy_q,
   input wire logic        flag_n_q,
   input wire logic        flag_z_q,
   input wire logic        flag_v_q,
   input wire logic        flag_c_q
);
   // ********
   // request decode
   // ********
   logic go;
   logic take;
   assign go = op_valid && !busy_q;
   assign take = go && !op_word && !op_use_imm;
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   a_answer_next: assert property (go && op_code != op_unsigned_divide |=> result_valid_q)
      else $error("single-cycle answer missing");
   a_sub_imm_refused: assert property (go && op_code == op_sub && op_use_imm |=> rejected_q)
      else $error("subtract with immediate not refused");
   a_word_imm_refused: assert property (go && op_word && op_use_imm
      && op_code inside {op_add, op_compare_operands} |=> rejected_q && !result_write_q)
      else $error("word immediate form not refused");
   a_word_add_sum: assert property (go && op_word && !op_use_imm && op_code == op_add
      |=> result_q == $past(dst_value) + $past(src_value)) else $error("word add wrong");
   a_step_up_one: assert property (take && op_code == op_step_up_by_one
      |=> result_q[7:0] == $past(dst_value[7:0]) + 8'h01) else $error("step up wrong");
   a_compare_no_write: assert property (go && !op_word && op_code == op_compare_operands
      |=> result_valid_q && !result_write_q) else $error("compare wrote a result");
   a_logic_zero_flag: assert property (go && !op_word && op_code inside {op_and, op_or, op_xor}
      |=> flag_z_q == (result_q[7:0] == 8'h00) && !flag_v_q) else $error("logic flags wrong");
   a_shift_carry_out: assert property (take && op_code == op_logical_right_shift
      |=> flag_c_q == $past(dst_value[0]) && !result_q[7]) else $error("shift carry wrong");
   a_divide_span: assert property (take && op_code == op_unsigned_divide
      |=> busy_q ##[1:10] result_valid_q) else $error("divide answer late");
   c_divide: cover property (take && op_code == op_unsigned_divide);
   c_reject: cover property (rejected_q);
   c_compare: cover property (go && op_code == op_compare_operands);
endmodule : alu_core_properties

bind alu_core alu_core_properties i_props (.ref_clk, .resetn, .op_valid, .op_code, .op_word,
   .op_use_imm, .dst_value, .src_value, .result_q, .result_write_q, .result_valid_q,
   .rejected_q, .busy_q, .flag_n_q, .flag_z_q, .flag_v_q, .flag_c_q);

// ==== test/reg_file_model.sv ====
`timescale 1ns/1ps
module reg_file_model (
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic [15:0] result_q,
   input  wire logic        result_write_q,
   output logic      [15:0] rd_q
);
   // ********
   // destination write-back, only on the write pulse
   // ********
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rd_q <= 16'h0000;
      end else if (result_write_q) begin
         rd_q <= result_q;
      end
   end
endmodule : reg_file_model

// ==== test/test_cpu_arith_logic_shift_unit.sv ====
`timescale 1ns/1ps
module test_cpu_arith_logic_shift_unit;
   import alu_pkg::*;
   logic        ref_clk, resetn, op_valid, op_word, op_use_imm, small_const_two, w, im;
   logic        result_write_q, result_valid_q, rejected_q, busy_q, mn, mz, mc, mh;
   logic        flag_n_q, flag_z_q, flag_v_q, flag_c_q, flag_h_q;
   logic [15:0] dst_value, src_value, imm_value, result_q, rd_q, d, s, b;
   op_t         op_code, o;
   int          n_errors, check_count, seed;
   alu_core i_dut (.ref_clk, .resetn, .op_valid, .op_code, .op_word, .op_use_imm,
      .small_const_two, .dst_value, .src_value, .imm_value, .result_q, .result_write_q,
      .result_valid_q, .rejected_q, .busy_q, .flag_n_q, .flag_z_q, .flag_v_q, .flag_c_q,
      .flag_h_q);
   reg_file_model i_rf (.ref_clk, .resetn, .result_q, .result_write_q, .rd_q);
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   // ********
   // reference model, then one request and its answer
   // ********
   task automatic run(op_t op, logic w, logic im, logic [15:0] d, logic [15:0] s);
      logic [16:0] x, y, u;
      logic [15:0] r;
      logic        rj, wr;
      int          k;
      x = w ? {1'b0, d} : {9'h000, d[7:0]};
      y = w ? {1'b0, s} : {9'h000, s[7:0]};
      rj = (op == op_sub || w) && im;
      wr = !rj && op != op_compare_operands;
      case (op)
         op_add: u = x + y;
         op_sub, op_compare_operands: u = x - y;
         op_add_with_carry: u = x + y + mc;
         op_subtract_with_borrow: u = x - y - mc;
         op_step_up_by_one: u = x + 1;
         op_step_down_by_one: u = x - 1;
         op_arithmetic_complement: u = 0 - x;
         op_and: u = x & y;
         op_or: u = x | y;
         op_xor: u = x ^ y;
         op_not: u = ~x;
         op_arith_left_shift, op_logical_left_shift: u = {8'h00, d[7:0], 1'b0};
         op_arith_right_shift: u = {8'h00, d[0], d[7], d[7:1]};
         op_logical_right_shift: u = {8'h00, d[0], 1'b0, d[7:1]};
         op_rotate_left: u = {8'h00, d[7:0], d[7]};
         op_rotate_right: u = {8'h00, d[0], d[0], d[7:1]};
         op_rotate_left_through_carry: u = {8'h00, d[7:0], mc};
         op_rotate_right_through_carry: u = {8'h00, d[0], mc, d[7:1]};
         op_decimal_adjust_after_add: u = {8'h00, mc || x > 17'h99, 8'(x[7:0]
            + (mh || x[3:0] > 4'h9 ? 8'h06 : 8'h00) + (mc || x > 17'h99 ? 8'h60 : 8'h00))};
         op_decimal_adjust_after_subtract: u = {8'h00, mc,
            8'(x[7:0] - (mh ? 8'h06 : 8'h00) - (mc ? 8'h60 : 8'h00))};
         default: u = 17'h0_0000;
      endcase
      r = w ? u[15:0] : {d[15:8], u[7:0]};
      case (op)
         op_unsigned_multiply: r = d[7:0] * s[7:0];
         op_unsigned_divide: r = {8'(d % s[7:0]), 8'(d / s[7:0])};
         op_word_small_constant_add: r = d + (s[0] ? 16'h0002 : 16'h0001);
         op_word_small_constant_subtract: r = d - (s[0] ? 16'h0002 : 16'h0001);
         default: ;
      endcase
      if (!rj && !(op inside {op_unsigned_multiply, op_word_small_constant_add,
                              op_word_small_constant_subtract})) begin
         mn = w ? r[15] : r[7];
         mz = op != op_unsigned_divide && (w ? r == 16'h0000 : r[7:0] == 8'h00);
         if (!(op inside {op_step_up_by_one, op_step_down_by_one, op_and, op_or, op_xor,
                          op_not, op_unsigned_divide})) mc = w ? u[16] : u[8];
         if (!w && op inside {op_add, op_sub, op_compare_operands, op_add_with_carry,
                              op_subtract_with_borrow, op_arithmetic_complement})
            mh = u[4] ^ x[4] ^ (op != op_arithmetic_complement && y[4]);
      end
      @(negedge ref_clk);
      op_valid = 1'b1;
      op_code = op;
      op_word = w;
      op_use_imm = im;
      small_const_two = s[0];
      dst_value = d;
      src_value = im ? ~s : s;
      imm_value = s;
      @(negedge ref_clk);
      op_valid = 1'b0;
      for (k = 0; k < 20 && result_valid_q !== 1'b1; k++) @(negedge ref_clk);
      chk("valid", 16'h0001, {15'h0000, result_valid_q});
      chk("rejected", {15'h0000, rj}, {15'h0000, rejected_q});
      chk("write", {15'h0000, wr}, {15'h0000, result_write_q});
      if (wr) chk("result", r, result_q);
      chk("flags", {13'h0000, mn, mz, mc}, {13'h0000, flag_n_q, flag_z_q, flag_c_q});
      chk("half", {15'h0000, mh}, {15'h0000, flag_h_q});
      @(negedge ref_clk);
      if (wr) chk("rd", r, rd_q);
   endtask : run
   initial begin
      seed = 7;
      n_errors = 0;
      check_count = 0;
      {mn, mz, mc, mh} = 4'h0;
      resetn = 1'b0;
      {op_valid, op_word, op_use_imm, small_const_two} = 4'h0;
      op_code = op_add;
      {dst_value, src_value, imm_value} = 48'h0000_0000_0000;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      resetn = 1'b1;
      run(op_add, 1'b0, 1'b0, 16'h0005, 16'h0003);
      run(op_unsigned_divide, 1'b0, 1'b0, 16'h0064, 16'h0007);
      for (int j = 0; j < 600; j++) begin
         o = op_t'(5'($unsigned($random(seed)) % 26));
         d = $random(seed);
         s = $random(seed);
         b = $random(seed);
         w = (b[0] && o inside {op_add, op_sub, op_compare_operands})
             || o inside {op_word_small_constant_add, op_word_small_constant_subtract};
         im = b[1] && o inside {op_add, op_sub, op_compare_operands, op_add_with_carry,
                                op_subtract_with_borrow, op_and, op_or, op_xor};
         if (o == op_unsigned_divide) begin
            s[7:0] = s[7:0] | 8'h01;
            d[15:8] = d[15:8] % s[7:0];
         end
         run(o, w, im, d, s);
      end
      stop_test;
   end
   initial begin
      #1_000_000;
      n_errors++;
      stop_test;
   end
endmodule : test_cpu_arith_logic_shift_unit
